/* src/srs_pkg.sv */
// package with addresses, field layouts, reset values and carriers for the serial access block
// Operation
// R1: month stamp bits 7-5 hold a day-of-week code from 1 to 7, user meaning
// R2: month stamp bit 4 holds the month tens digit, 0 or 1
// R3: month stamp bits 3-0 hold the month ones digit, 0 to 9
// R4: unimplemented register bits always read as zero
// R5: the 64-byte memory keeps its contents while backup supply is present and enabled
// R6: one control byte serves both regions; only the address byte picks a region
// R7: timekeeping space sits at 0x00-0x1F, memory at 0x20-0x5F
// R8: memory access never stalls while timekeeping registers update internally
// R9: power-on reset leaves memory contents untouched and undefined
// R10: on backup supply every serial access is refused
// R11: byte write: control, address, data, each acknowledged; address loads pointer
// R12: write address above 0x5F: address and data unacknowledged, nothing stored
// R13: after a byte write the pointer holds the next address
// R14: sequential write: every further byte is acknowledged, stored, pointer advances
// R15: pointer wraps 0x1F to 0x00 and 0x5F to 0x20
// R16: current-address read returns the byte at last accessed address plus one
// R17: random read: address written, repeated start, one byte read, pointer advances
// R18: sequential read continues while the master acknowledges; nack and stop end it
// R19: stamps record only with power-loss flag clear; clearing the flag clears all stamps
// R20: backup supply is used only when the backup-supply enable bit is set
// R21: a control byte with another device code is ignored and the bus stays released
package srs_pkg;
    localparam logic [6:0] SRS_DEV_CODE = 7'h6f; // control byte 1101111x
    localparam logic [6:0] SRS_RTC_FIRST = 7'h00;
    localparam logic [6:0] SRS_RTC_LAST = 7'h1f;
    localparam logic [6:0] SRS_SRAM_FIRST = 7'h20;
    localparam logic [6:0] SRS_SRAM_LAST = 7'h5f;
    localparam int SRS_RTC_DEPTH = 32;
    localparam int SRS_SRAM_DEPTH = 64;
    // register offsets inside the timekeeping space
    localparam logic [4:0] SRS_WEEKDAY_ADDR = 5'h03;
    localparam logic [4:0] SRS_PD_MIN_ADDR = 5'h18;
    localparam logic [4:0] SRS_PD_HOUR_ADDR = 5'h19;
    localparam logic [4:0] SRS_PD_DATE_ADDR = 5'h1a;
    localparam logic [4:0] SRS_PD_MONTH_ADDR = 5'h1b;
    localparam logic [4:0] SRS_PU_MIN_ADDR = 5'h1c;
    localparam logic [4:0] SRS_PU_HOUR_ADDR = 5'h1d;
    localparam logic [4:0] SRS_PU_DATE_ADDR = 5'h1e;
    localparam logic [4:0] SRS_PU_MONTH_ADDR = 5'h1f;
    // implemented-bit masks
    localparam logic [7:0] SRS_MIN_MASK = 8'h7f;
    localparam logic [7:0] SRS_HOUR_MASK = 8'h7f;
    localparam logic [7:0] SRS_DATE_MASK = 8'h3f;
    localparam logic [7:0] SRS_MONTH_MASK = 8'hff;
    localparam logic [7:0] SRS_WEEKDAY_STORE_MASK = 8'h0f;
    localparam logic [7:0] SRS_FULL_MASK = 8'hff;
    // weekday register field positions
    localparam int SRS_OSC_RUN_BIT = 5;
    localparam int SRS_PWR_LOSS_BIT = 4;
    localparam int SRS_BKUP_EN_BIT = 3;
    // month stamp field positions
    localparam int SRS_DOW_MSB = 7;
    localparam int SRS_DOW_LSB = 5;
    localparam int SRS_MTH_TEN_BIT = 4;
    localparam int SRS_MTH_ONE_MSB = 3;
    localparam logic [7:0] SRS_REG_RESET = 8'h00;
    localparam logic [6:0] SRS_PTR_RESET = 7'h00;

    // time value handed over by the timekeeping logic
    typedef struct packed {
        logic [7:0] minute;
        logic [7:0] hour;
        logic [7:0] date;
        logic [7:0] month;
    } srs_stamp_t;

    // one registered write into either region
    typedef struct packed {
        logic en;
        logic [6:0] addr;
        logic [7:0] data;
    } srs_write_t;

    typedef enum logic [2:0] {
        SRS_IDLE,
        SRS_CTRL,
        SRS_ADDR,
        SRS_WDATA,
        SRS_RDATA,
        SRS_SKIP
    } srs_state_t;
endpackage : srs_pkg

/* src/srs_serial_access.sv */
// two-wire serial slave giving byte access to timekeeping registers and general memory
`timescale 1ns/1ns
module srs_serial_access (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire logic i_sda,
    output logic o_sda_out,
    output logic o_sda_oe,
    input wire logic i_on_backup,
    input wire logic i_osc_running,
    input wire logic i_pwr_down_evt,
    input wire logic i_pwr_up_evt,
    input wire srs_pkg::srs_stamp_t i_stamp,
    output logic o_backup_supply_enable,
    output logic o_power_loss_flag
);
    import srs_pkg::*;

    // pointer step with wrap inside each region
    function automatic logic [6:0] srs_next_ptr(input logic [6:0] p);
        logic [6:0] n;
        n = p + 7'h01;
        if (p == SRS_RTC_LAST) begin
            n = SRS_RTC_FIRST; // R15
        end else if (p == SRS_SRAM_LAST) begin
            n = SRS_SRAM_FIRST; // R15
        end
        return n;
    endfunction : srs_next_ptr

    // implemented bits of each timekeeping location
    function automatic logic [7:0] srs_mask(input logic [4:0] a);
        logic [7:0] m;
        m = SRS_FULL_MASK;
        case (a)
            SRS_PD_MIN_ADDR, SRS_PU_MIN_ADDR: m = SRS_MIN_MASK;
            SRS_PD_HOUR_ADDR, SRS_PU_HOUR_ADDR: m = SRS_HOUR_MASK;
            SRS_PD_DATE_ADDR, SRS_PU_DATE_ADDR: m = SRS_DATE_MASK;
            SRS_PD_MONTH_ADDR, SRS_PU_MONTH_ADDR: m = SRS_MONTH_MASK;
            SRS_WEEKDAY_ADDR: m = SRS_WEEKDAY_STORE_MASK;
            default: m = SRS_FULL_MASK;
        endcase
        return m;
    endfunction : srs_mask

    // pin synchronisers: scl, sda, backup, oscillator
    logic [3:0] pin_meta_reg;
    logic [3:0] pin_sync_reg;
    logic [1:0] bus_prev_reg;

    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            pin_meta_reg <= 4'hf;
            pin_sync_reg <= 4'hf;
            bus_prev_reg <= 2'h3;
        end else begin
            pin_meta_reg <= {i_osc_running, i_on_backup, i_sda, i_scl};
            pin_sync_reg <= pin_meta_reg;
            bus_prev_reg <= pin_sync_reg[1:0];
        end
    end

    wire scl_s = pin_sync_reg[0];
    wire sda_s = pin_sync_reg[1];
    wire scl_p = bus_prev_reg[0];
    wire sda_p = bus_prev_reg[1];
    wire osc_run_s = pin_sync_reg[3];

    // bus conditions found from the sampled lines
    wire scl_rise = scl_s && !scl_p;
    wire scl_fall = !scl_s && scl_p;
    wire start_cond = scl_s && scl_p && sda_p && !sda_s;
    wire stop_cond = scl_s && scl_p && !sda_p && sda_s;

    // storage: timekeeping registers, flag, general memory
    logic [7:0] rtc_reg [SRS_RTC_DEPTH];
    logic power_loss_flag_reg;
    logic [7:0] sram_mem [SRS_SRAM_DEPTH];
    srs_write_t wr_reg;

    // backup path only counts when its enable bit is set
    wire backup_supply_enable = rtc_reg[SRS_WEEKDAY_ADDR][SRS_BKUP_EN_BIT];
    wire on_backup = pin_sync_reg[2] && backup_supply_enable; // R20

    // read data for the current pointer
    logic [6:0] ptr_reg;
    wire [6:0] sram_off = ptr_reg - SRS_SRAM_FIRST;
    wire [4:0] rtc_idx = ptr_reg[4:0];
    wire [7:0] rtc_raw = rtc_reg[rtc_idx];
    wire [7:0] weekday_rd = {2'b00, osc_run_s, power_loss_flag_reg, rtc_raw[3:0]}; // R4
    wire [7:0] month_rd = {rtc_raw[SRS_DOW_MSB:SRS_DOW_LSB], // R1
                           rtc_raw[SRS_MTH_TEN_BIT], // R2
                           rtc_raw[SRS_MTH_ONE_MSB:0]}; // R3
    wire is_month = (rtc_idx == SRS_PD_MONTH_ADDR) || (rtc_idx == SRS_PU_MONTH_ADDR);
    wire [7:0] rtc_rd = (rtc_idx == SRS_WEEKDAY_ADDR) ? weekday_rd :
                        is_month ? month_rd : (rtc_raw & srs_mask(rtc_idx)); // R4
    wire in_rtc = (ptr_reg <= SRS_RTC_LAST); // R7
    wire [7:0] rd_byte = in_rtc ? rtc_rd : sram_mem[sram_off[5:0]]; // R7 R8

    // serial protocol state
    srs_state_t state_reg;
    logic [3:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] tx_reg;
    logic rw_reg;
    logic addr_bad_reg;
    logic mack_reg;
    logic sda_oe_reg;
    logic scl_seen_reg;

    // byte just completed: used at the scl fall after the rise that took the eighth bit
    wire [7:0] rx_byte = shift_reg;
    wire ctrl_match = (rx_byte[7:1] == SRS_DEV_CODE); // R6 R21
    wire addr_ok = (rx_byte[6:0] <= SRS_SRAM_LAST) && !rx_byte[7]; // R12
    wire receiving = (state_reg == SRS_CTRL) || (state_reg == SRS_ADDR) ||
                     (state_reg == SRS_WDATA);

    // protocol engine, stepped by scl edges and bus conditions
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            state_reg <= SRS_IDLE;
            bit_cnt_reg <= 4'h0;
            shift_reg <= SRS_REG_RESET;
            tx_reg <= SRS_REG_RESET;
            rw_reg <= 1'b0;
            addr_bad_reg <= 1'b0;
            mack_reg <= 1'b0;
            scl_seen_reg <= 1'b0;
            sda_oe_reg <= 1'b0;
            ptr_reg <= SRS_PTR_RESET;
            wr_reg <= '0;
        end else begin
            wr_reg.en <= 1'b0;
            if (on_backup) begin
                state_reg <= SRS_IDLE; // R10
                sda_oe_reg <= 1'b0; // R10
            end else if (stop_cond) begin
                state_reg <= SRS_IDLE; // R18
                sda_oe_reg <= 1'b0;
            end else if (start_cond) begin
                state_reg <= SRS_CTRL; // R11 R17
                scl_seen_reg <= 1'b0; // the fall that closes a start is not a bit
                bit_cnt_reg <= 4'h0;
                addr_bad_reg <= 1'b0;
                sda_oe_reg <= 1'b0;
            end else if (scl_rise && state_reg != SRS_IDLE) begin
                scl_seen_reg <= 1'b1;
                if (bit_cnt_reg < 4'h8) begin
                    if (receiving) begin
                        shift_reg <= {shift_reg[6:0], sda_s};
                    end
                end else begin
                    mack_reg <= !sda_s; // R18
                end
            end else if (scl_fall && scl_seen_reg &&
                         state_reg != SRS_IDLE && state_reg != SRS_SKIP) begin
                if (bit_cnt_reg < 4'h7) begin
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                    if (state_reg == SRS_RDATA) begin
                        tx_reg <= {tx_reg[6:0], 1'b0};
                        sda_oe_reg <= !tx_reg[6];
                    end
                end else if (bit_cnt_reg == 4'h7) begin
                    // eighth bit over: drive or skip the acknowledge
                    bit_cnt_reg <= 4'h8;
                    case (state_reg)
                        SRS_CTRL: begin
                            if (ctrl_match) begin
                                sda_oe_reg <= 1'b1; // R11
                                rw_reg <= rx_byte[0];
                            end else begin
                                state_reg <= SRS_SKIP; // R21
                            end
                        end
                        SRS_ADDR: begin
                            if (addr_ok) begin
                                sda_oe_reg <= 1'b1; // R11
                                ptr_reg <= rx_byte[6:0]; // R11 R17
                            end else begin
                                addr_bad_reg <= 1'b1; // R12
                            end
                        end
                        SRS_WDATA: begin
                            if (!addr_bad_reg) begin
                                sda_oe_reg <= 1'b1; // R14
                                wr_reg.en <= 1'b1; // R11 R14
                                wr_reg.addr <= ptr_reg;
                                wr_reg.data <= rx_byte;
                                ptr_reg <= srs_next_ptr(ptr_reg); // R13 R14
                            end
                        end
                        SRS_RDATA: begin
                            sda_oe_reg <= 1'b0; // master answers this slot
                        end
                        default: begin
                            sda_oe_reg <= 1'b0;
                        end
                    endcase
                end else begin
                    // acknowledge slot over: next byte
                    bit_cnt_reg <= 4'h0;
                    sda_oe_reg <= 1'b0;
                    case (state_reg)
                        SRS_CTRL: begin
                            if (rw_reg) begin
                                state_reg <= SRS_RDATA; // R16
                                tx_reg <= rd_byte;
                                sda_oe_reg <= !rd_byte[7];
                                ptr_reg <= srs_next_ptr(ptr_reg); // R16 R17
                            end else begin
                                state_reg <= SRS_ADDR;
                            end
                        end
                        SRS_ADDR: begin
                            state_reg <= SRS_WDATA;
                        end
                        SRS_WDATA: begin
                            state_reg <= SRS_WDATA;
                        end
                        SRS_RDATA: begin
                            if (mack_reg) begin
                                tx_reg <= rd_byte; // R18
                                sda_oe_reg <= !rd_byte[7];
                                ptr_reg <= srs_next_ptr(ptr_reg); // R18
                            end else begin
                                state_reg <= SRS_SKIP; // R16 R18
                            end
                        end
                        default: begin
                            state_reg <= SRS_SKIP;
                        end
                    endcase
                end
            end
        end
    end

    // decode of the registered write
    wire wr_rtc = wr_reg.en && (wr_reg.addr <= SRS_RTC_LAST);
    wire wr_sram = wr_reg.en && (wr_reg.addr >= SRS_SRAM_FIRST);
    wire [4:0] wr_idx = wr_reg.addr[4:0];
    wire [6:0] wr_off = wr_reg.addr - SRS_SRAM_FIRST;
    wire flag_clear = wr_rtc && (wr_idx == SRS_WEEKDAY_ADDR) &&
                      !wr_reg.data[SRS_PWR_LOSS_BIT] && power_loss_flag_reg; // R19
    wire stamp_ok = !power_loss_flag_reg || flag_clear; // R19

    // timekeeping registers, flag and time-stamp capture
    always_ff @(posedge i_core_clk or negedge i_rst_n) begin
        if (!i_rst_n) begin
            for (int i = 0; i < SRS_RTC_DEPTH; i++) begin
                rtc_reg[i] <= SRS_REG_RESET;
            end
            power_loss_flag_reg <= 1'b0;
        end else begin
            if (wr_rtc) begin
                rtc_reg[wr_idx] <= wr_reg.data & srs_mask(wr_idx); // R4
            end
            if (flag_clear) begin
                power_loss_flag_reg <= 1'b0; // R19
                for (int i = SRS_PD_MIN_ADDR; i <= SRS_PU_MONTH_ADDR; i++) begin
                    rtc_reg[i] <= SRS_REG_RESET; // R19
                end
            end
            if (i_pwr_down_evt && stamp_ok) begin
                rtc_reg[SRS_PD_MIN_ADDR] <= i_stamp.minute & SRS_MIN_MASK; // R19
                rtc_reg[SRS_PD_HOUR_ADDR] <= i_stamp.hour & SRS_HOUR_MASK;
                rtc_reg[SRS_PD_DATE_ADDR] <= i_stamp.date & SRS_DATE_MASK;
                rtc_reg[SRS_PD_MONTH_ADDR] <= i_stamp.month;
            end
            if (i_pwr_up_evt && stamp_ok) begin
                rtc_reg[SRS_PU_MIN_ADDR] <= i_stamp.minute & SRS_MIN_MASK; // R19
                rtc_reg[SRS_PU_HOUR_ADDR] <= i_stamp.hour & SRS_HOUR_MASK;
                rtc_reg[SRS_PU_DATE_ADDR] <= i_stamp.date & SRS_DATE_MASK;
                rtc_reg[SRS_PU_MONTH_ADDR] <= i_stamp.month;
                power_loss_flag_reg <= 1'b1; // set wins over clear
            end
        end
    end

    // general memory: no reset, contents kept across resets
    always_ff @(posedge i_core_clk) begin
        if (wr_sram) begin
            sram_mem[wr_off[5:0]] <= wr_reg.data; // R5 R8 R9
        end
    end

    // open-drain data line and status outputs
    assign o_sda_out = 1'b0;
    assign o_sda_oe = sda_oe_reg; // R21
    assign o_backup_supply_enable = backup_supply_enable; // R20
    assign o_power_loss_flag = power_loss_flag_reg;
endmodule : srs_serial_access

/* sim/srs_serial_access_checker.sv */
// concurrent checks on the serial access block ports
`timescale 1ns/1ns
module srs_serial_access_checker (
    input wire logic i_core_clk,
    input wire logic i_rst_n,
    input wire logic i_scl,
    input wire logic o_sda_oe,
    input wire logic i_on_backup,
    input wire logic i_pwr_down_evt,
    input wire logic i_pwr_up_evt,
    input wire logic o_backup_supply_enable,
    input wire logic o_power_loss_flag
);
    default clocking cb @(posedge i_core_clk);
    endclocking
    default disable iff (!i_rst_n);
    // data line only moves while the serial clock is low
    oe_scl_low_a: assert property ($changed(o_sda_oe) |-> !i_scl)
        else $error("data line moved while clock high");
    // a pulled bit stands for at least eight core cycles
    ack_hold_a: assert property ($rose(o_sda_oe) |-> o_sda_oe [*8])
        else $error("pulled bit released too early");
    oe_bounded_a: assert property ($rose(o_sda_oe) |-> ##[1:110] !o_sda_oe)
        else $error("data line held low too long");
    // no serial answer while running on an enabled backup supply
    backup_quiet_a: assert property (
        (i_on_backup && o_backup_supply_enable) [*6] |-> !o_sda_oe)
        else $error("answer given on backup supply");
    up_sets_flag_a: assert property (i_pwr_up_evt |=> o_power_loss_flag)
        else $error("power-up event did not set flag");
    flag_cause_a: assert property ($rose(o_power_loss_flag) |-> $past(i_pwr_up_evt))
        else $error("flag set without power-up event");
    down_no_flag_a: assert property (
        i_pwr_down_evt && !i_pwr_up_evt && !o_power_loss_flag |=> !o_power_loss_flag)
        else $error("power-down event set flag");
    // power-loss flag clears and backup enable changes only at an acknowledged store
    flag_clear_a: assert property ($fell(o_power_loss_flag) |-> o_sda_oe && !i_scl)
        else $error("flag cleared outside a store");
    enable_write_a: assert property (
        $changed(o_backup_supply_enable) |-> o_sda_oe && !i_scl)
        else $error("backup enable changed outside a store");
endmodule : srs_serial_access_checker

bind srs_serial_access srs_serial_access_checker i_srs_serial_access_checker (
    .i_core_clk(i_core_clk), .i_rst_n(i_rst_n), .i_scl(i_scl), .o_sda_oe(o_sda_oe),
    .i_on_backup(i_on_backup), .i_pwr_down_evt(i_pwr_down_evt),
    .i_pwr_up_evt(i_pwr_up_evt), .o_backup_supply_enable(o_backup_supply_enable),
    .o_power_loss_flag(o_power_loss_flag)
);

/* sim/srs_i2c_master.sv */
// two-wire bus master model: drives the clock, pulls the data line low
`timescale 1ns/1ns
module srs_i2c_master (
    input wire logic i_clk,
    input wire logic i_sda,
    output logic o_scl,
    output logic o_sda_oe
);
    // idle bus: clock high, data released
    initial begin
        o_scl = 1'b1;
        o_sda_oe = 1'b0;
    end
    // wait n core cycles and step just past the edge
    task automatic hp(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : hp
    // start or repeated start: data falls while clock high
    task automatic start();
        hp(4);
        o_sda_oe = 1'b0;
        hp(4);
        o_scl = 1'b1;
        hp(4);
        o_sda_oe = 1'b1;
        hp(4);
        o_scl = 1'b0;
    endtask : start
    // stop: data rises while clock high, clock then stands still
    task automatic stop();
        hp(4);
        o_sda_oe = 1'b1;
        hp(4);
        o_scl = 1'b1;
        hp(4);
        o_sda_oe = 1'b0;
        hp(4);
    endtask : stop
    // eight bits msb first, then the ninth slot; 8 low plus 4 high cycles a bit
    task automatic xfer(input logic [7:0] tx, input logic mack,
                        output logic [7:0] rx, output logic nak);
        logic [8:0] bits;
        bits = {tx, mack};
        for (int i = 8; i >= 0; i--) begin
            hp(4);
            o_sda_oe = !bits[i];
            hp(4);
            o_scl = 1'b1;
            hp(2);
            if (i > 0) rx[i-1] = i_sda;
            else nak = i_sda;
            hp(2);
            o_scl = 1'b0;
        end
    endtask : xfer
endmodule : srs_i2c_master

/* sim/tb_top.sv */
// self-checking bench for the serial register and memory access block
`timescale 1ns/1ns
module tb_top;
    import srs_pkg::*;
    typedef logic [7:0] srs_bq_t[$];
    localparam logic [7:0] wctl = {SRS_DEV_CODE, 1'b0};
    logic core_clk = 1'b0;
    logic rst_n = 1'b0;
    logic on_backup = 1'b0;
    logic osc_run = 1'b1;
    logic dn_evt = 1'b0;
    logic up_evt = 1'b0;
    logic scl, m_oe, sda_out, sda_oe, bk_en, flag, nak;
    logic [7:0] rx;
    srs_stamp_t stamp = 32'h0000_0000;
    int failures = 0;
    int samples_checked = 0;
    // rows: address, data written, value read back
    logic [23:0] rows [8] = '{24'h03_c727, 24'h18_ff7f, 24'h1a_ff3f, 24'h1b_b2b2,
                              24'h1f_4141, 24'h00_5a5a, 24'h20_a5a5, 24'h5f_3c3c};
    wire sda = !(m_oe || sda_oe); // pull-up unless someone pulls low
    always #2 core_clk = ~core_clk;
    srs_serial_access i_srs_serial_access (.i_core_clk(core_clk), .i_rst_n(rst_n),
        .i_scl(scl), .i_sda(sda), .o_sda_out(sda_out), .o_sda_oe(sda_oe),
        .i_on_backup(on_backup), .i_osc_running(osc_run), .i_pwr_down_evt(dn_evt),
        .i_pwr_up_evt(up_evt), .i_stamp(stamp), .o_backup_supply_enable(bk_en),
        .o_power_loss_flag(flag));
    srs_i2c_master i_srs_i2c_master (.i_clk(core_clk), .i_sda(sda), .o_scl(scl),
        .o_sda_oe(m_oe));
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        samples_checked++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", n, e, g);
        end
    endtask : chk
    // write: ck and ak are the expected ninth-slot levels of control and later bytes
    task automatic wr(input logic [7:0] c, input logic ck, input logic [7:0] a,
                      input srs_bq_t d, input logic ak);
        i_srs_i2c_master.start();
        i_srs_i2c_master.xfer(c, 1'b1, rx, nak);
        chk("ctrl slot", 8'(ck), 8'(nak));
        i_srs_i2c_master.xfer(a, 1'b1, rx, nak);
        chk("addr slot", 8'(ak), 8'(nak));
        foreach (d[i]) begin
            i_srs_i2c_master.xfer(d[i], 1'b1, rx, nak);
            chk("data slot", 8'(ak), 8'(nak));
        end
        i_srs_i2c_master.stop();
    endtask : wr
    // read e.size() bytes, acking all but the last; cur skips the address phase
    task automatic rd(input logic [7:0] a, input logic cur, input srs_bq_t e);
        if (!cur) begin
            i_srs_i2c_master.start();
            i_srs_i2c_master.xfer(wctl, 1'b1, rx, nak);
            i_srs_i2c_master.xfer(a, 1'b1, rx, nak);
        end
        i_srs_i2c_master.start();
        i_srs_i2c_master.xfer({SRS_DEV_CODE, 1'b1}, 1'b1, rx, nak);
        chk("read ctrl slot", 8'h00, 8'(nak));
        foreach (e[i]) begin
            i_srs_i2c_master.xfer(8'hff, i == e.size() - 1, rx, nak);
            chk("read data", e[i], rx);
        end
        i_srs_i2c_master.stop();
    endtask : rd
    // one-cycle time-stamp event
    task automatic ev(input logic up, input logic [31:0] s);
        @(posedge core_clk);
        #1;
        stamp = s;
        up_evt = up;
        dn_evt = !up;
        @(posedge core_clk);
        #1;
        {up_evt, dn_evt} = 2'b00;
    endtask : ev
    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", samples_checked, failures);
        if (failures == 0 && samples_checked > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : print_verdict
    // hang guard
    initial begin
        repeat (80000) @(posedge core_clk);
        failures++;
        print_verdict();
    end
    // main sequence
    initial begin
        repeat (16) @(posedge core_clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge core_clk);
        chk("reset outputs", 8'h00, 8'({sda_oe, bk_en, flag}));
        rd(8'h1b, 0, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        foreach (rows[i]) begin
            wr(wctl, 0, rows[i][23:16], '{rows[i][15:8]}, 0);
            rd(rows[i][23:16], 0, '{rows[i][7:0]});
        end
        $display("test table finished");
        wr(wctl, 0, 8'h5f, '{8'h22, 8'h33, 8'h44}, 0);
        rd(8'h5f, 0, '{8'h22, 8'h33});
        rd(8'h00, 1, '{8'h44});
        wr(wctl, 0, 8'h20, '{8'h99}, 0);
        rd(8'h00, 1, '{8'h44});
        wr(wctl, 0, 8'h1f, '{8'h77, 8'h88}, 0);
        rd(8'h1f, 0, '{8'h77, 8'h88});
        $display("test wrap finished");
        wr(wctl, 0, 8'h60, '{8'h55}, 1);
        wr(wctl, 0, 8'hff, '{8'h55}, 1);
        wr(8'ha0, 1, 8'h20, '{8'h55}, 1);
        rd(8'h20, 0, '{8'h99, 8'h44});
        $display("test refusal finished");
        ev(0, 32'h1208_1523);
        ev(1, 32'h3409_1642);
        chk("power loss flag", 8'h01, 8'(flag));
        ev(0, 32'h5510_1763);
        rd(8'h18, 0, '{8'h12, 8'h08, 8'h15, 8'h23, 8'h34, 8'h09, 8'h16, 8'h42});
        rd(8'h03, 0, '{8'h37});
        wr(wctl, 0, 8'h03, '{8'h07}, 0);
        rd(8'h1b, 0, '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00});
        chk("power loss flag", 8'h00, 8'(flag));
        $display("test stamps finished");
        wr(wctl, 0, 8'h03, '{8'h0f}, 0);
        chk("backup enable", 8'h01, 8'(bk_en));
        on_backup = 1'b1;
        wr(wctl, 1, 8'h20, '{8'h01}, 1);
        on_backup = 1'b0;
        rd(8'h20, 0, '{8'h99});
        wr(wctl, 0, 8'h03, '{8'h07}, 0);
        on_backup = 1'b1;
        rd(8'h20, 0, '{8'h99});
        on_backup = 1'b0;
        $display("test backup finished");
        // a mid-run reset clears the registers and leaves the memory as it was
        osc_run = 1'b0;
        @(posedge core_clk);
        #1 rst_n = 1'b0;
        repeat (4) @(posedge core_clk);
        #1 rst_n = 1'b1;
        repeat (4) @(posedge core_clk);
        #1;
        chk("reset outputs", 8'h00, 8'({sda_oe, bk_en, flag}));
        chk("data drive level", 8'h00, 8'(sda_out));
        rd(8'h20, 0, '{8'h99});
        rd(8'h03, 0, '{8'h00});
        $display("test reset finished");
        print_verdict();
    end
endmodule : tb_top
